// ==== core/bais_pkg.sv ====
// constants and types shared by the byte alu instruction subset block
// assumes an apb master with byte addresses and 32-bit data
package bais_pkg;

  // ---------------------------------------------------------------
  // widths and depths
  // ---------------------------------------------------------------
  localparam int DATA_W    = 8;
  localparam int FADDR_W   = 7;
  localparam int FILE_DEPTH = 128;
  localparam int PC_W      = 13;
  localparam int STK_DEPTH = 8;
  localparam int STK_PTR_W = 3;
  localparam int APB_AW    = 8;
  localparam int APB_DW    = 32;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [APB_AW-1:0] REG_CTRL   = 8'h00;
  localparam logic [APB_AW-1:0] REG_STATUS = 8'h04;
  localparam logic [APB_AW-1:0] REG_WORK   = 8'h08;
  localparam logic [APB_AW-1:0] REG_PC     = 8'h0c;
  localparam logic [APB_AW-1:0] REG_WDT    = 8'h10;
  localparam logic [APB_AW-1:0] REG_FSEL   = 8'h14;
  localparam logic [APB_AW-1:0] REG_FDATA  = 8'h18;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_WDT_EN = 0;
  localparam int ST_CARRY    = 0;
  localparam int ST_HALF     = 1;
  localparam int ST_ZERO     = 2;
  localparam int ST_PD       = 3;
  localparam int ST_TO       = 4;
  localparam int ST_SLEEP    = 5;

  // ---------------------------------------------------------------
  // reset and fixed values
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0]    BYTE_ZERO  = 8'h00;
  localparam logic [DATA_W-1:0]    WDT_CLR    = 8'h00;
  localparam logic [DATA_W-1:0]    WDT_ONE    = 8'h01;
  localparam logic [DATA_W-1:0]    PRESC_MAX  = 8'hff;
  localparam logic [PC_W-1:0]      PC_RST     = 13'h0000;
  localparam logic [STK_PTR_W-1:0] PTR_RST    = 3'h0;
  localparam logic [STK_PTR_W-1:0] PTR_ONE    = 3'h1;
  localparam logic [FADDR_W-1:0]   FSEL_RST   = 7'h00;
  localparam logic [3:0]           NIB_ZERO   = 4'h0;
  localparam logic                 PD_RST     = 1'b1;
  localparam logic                 TO_RST     = 1'b1;
  localparam logic [APB_DW-1:0]    RDATA_ZERO = 32'h00000000;

  // ---------------------------------------------------------------
  // instruction codes and sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NOP, OP_INC_FILE, OP_OR_WORK_FILE, OP_ROT_LEFT,
    OP_ROT_RIGHT, OP_LIT_MINUS_WORK, OP_SLEEP, OP_RETURN
  } bais_op_t;

  typedef enum logic [1:0] {
    STATE_RUN, STATE_RET2, STATE_SLEEP
  } bais_state_t;

endpackage

// ==== core/bais_core.sv ====
// execution datapath for a subset of an 8-bit core's instructions
// assumes decode hands over one instruction per opValid/opReady beat
//
// Overview of operation
// [RL1] increment file byte, update zero flag
// [RL2] destination bit 0 to work, 1 to file
// [RL3] or work with file, zero flag only
// [RL4] rotate left through carry, carry only
// [RL5] rotate right through carry, carry only
// [RL6] old carry fills, shifted bit becomes carry
// [RL7] literal minus work, sets C, DC, Z
// [RL8] sleep clears watchdog and its prescaler
// [RL9] sleep clears powerdown, sets timeout bit
// [RL10] sleep halts oscillator, no more instructions
// [RL11] return pops stack into pc, two cycles
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module bais_core (
  // clock and reset
  input  wire logic                           core_clk,
  input  wire logic                           rst_b,
  input  wire logic                           clkEn,
  // decoded instruction
  input  wire logic                           opValid,
  input  wire bais_pkg::bais_op_t             opCode,
  input  wire logic [bais_pkg::FADDR_W-1:0]   fileAddr,
  input  wire logic                           destSel,
  input  wire logic [bais_pkg::DATA_W-1:0]    literalVal,
  output logic                                opReady,
  // return stack push from call logic
  input  wire logic                           callPush,
  input  wire logic [bais_pkg::PC_W-1:0]      callAddr,
  // core state
  output logic [bais_pkg::PC_W-1:0]           programCounter,
  output logic                                oscRun,
  output logic                                sleepMode,
  // apb slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [bais_pkg::APB_AW-1:0]    paddr,
  input  wire logic [bais_pkg::APB_DW-1:0]    pwdata,
  output logic [bais_pkg::APB_DW-1:0]         prdata,
  output logic                                pready,
  output logic                                pslverr
);
  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [8:0] addCarry(
    input logic [7:0] a,
    input logic [7:0] b,
    input logic       cin
  );
    addCarry = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  endfunction
  function automatic logic isMapped(input logic [bais_pkg::APB_AW-1:0] a);
    isMapped = (a == bais_pkg::REG_CTRL)  || (a == bais_pkg::REG_STATUS) ||
               (a == bais_pkg::REG_WORK)  || (a == bais_pkg::REG_PC) ||
               (a == bais_pkg::REG_WDT)   || (a == bais_pkg::REG_FSEL) ||
               (a == bais_pkg::REG_FDATA);
  endfunction
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [bais_pkg::DATA_W-1:0]    fileMem [bais_pkg::FILE_DEPTH];
  logic [bais_pkg::PC_W-1:0]      stackMem [bais_pkg::STK_DEPTH];
  bais_pkg::bais_state_t          state_ff, nxt_state;
  logic [bais_pkg::DATA_W-1:0]    work_ff;
  logic                           carry_ff, half_carry_flag_ff, zero_ff;
  logic                           powerdown_status_bit_ff, timeout_status_bit_ff;
  logic [bais_pkg::DATA_W-1:0]    watchdog_counter_ff, presc_ff;
  logic                           wdtEn_ff;
  logic [bais_pkg::PC_W-1:0]      program_counter_ff;
  logic [bais_pkg::STK_PTR_W-1:0] stkPtr_ff;
  logic [bais_pkg::FADDR_W-1:0]   fsel_ff;
  logic [bais_pkg::APB_DW-1:0]    rdata_ff;
  logic                           rdErr_ff;
  // ---------------------------------------------------------------
  // execute decode
  // ---------------------------------------------------------------
  logic                           take;
  logic [bais_pkg::DATA_W-1:0]    fileOp;
  logic [8:0]                     incSum, subSum, subNib;
  logic [bais_pkg::DATA_W-1:0]    result;
  logic                           wrWork, wrFile;
  logic                           updZero, updCarry, updHalf;
  logic                           newCarry;
  logic                           doSleep, doReturn;
  logic                           pushTake;
  logic                           apbSetup, apbWrite;
  logic                           busWork, busStat;
  logic [bais_pkg::STK_PTR_W-1:0] popIdx;
  assign opReady  = (state_ff == bais_pkg::STATE_RUN);
  assign take     = opValid && opReady && clkEn;
  assign fileOp   = fileMem[fileAddr];
  assign incSum   = addCarry(fileOp, bais_pkg::BYTE_ZERO, 1'b1);
  // k - w as k + ~w + 1: carry out high means no borrow
  assign subSum   = addCarry(literalVal, ~work_ff, 1'b1);
  assign subNib   = addCarry({bais_pkg::NIB_ZERO, literalVal[3:0]},
                             {bais_pkg::NIB_ZERO, ~work_ff[3:0]}, 1'b1);
  assign popIdx   = stkPtr_ff - bais_pkg::PTR_ONE;
  // return wins over a push offered in the same cycle
  assign pushTake = callPush && clkEn && opReady && !(take && doReturn);
  always_comb begin
    result   = bais_pkg::BYTE_ZERO;
    wrWork   = 1'b0;
    wrFile   = 1'b0;
    updZero  = 1'b0;
    updCarry = 1'b0;
    updHalf  = 1'b0;
    newCarry = carry_ff;
    doSleep  = 1'b0;
    doReturn = 1'b0;
    if (opValid && opReady) begin
      case (opCode)
        bais_pkg::OP_INC_FILE: begin
          result  = incSum[7:0]; // RL1
          wrWork  = !destSel; // RL2
          wrFile  = destSel; // RL2
          updZero = 1'b1; // RL1
        end
        bais_pkg::OP_OR_WORK_FILE: begin
          result  = work_ff | fileOp; // RL3
          wrWork  = !destSel; // RL2
          wrFile  = destSel; // RL2
          updZero = 1'b1; // RL3
        end
        bais_pkg::OP_ROT_LEFT: begin
          result   = {fileOp[6:0], carry_ff}; // RL4 RL6
          newCarry = fileOp[7]; // RL6
          updCarry = 1'b1; // RL4
          wrWork   = !destSel; // RL2
          wrFile   = destSel; // RL2
        end
        bais_pkg::OP_ROT_RIGHT: begin
          result   = {carry_ff, fileOp[7:1]}; // RL5 RL6
          newCarry = fileOp[0]; // RL6
          updCarry = 1'b1; // RL5
          wrWork   = !destSel; // RL2
          wrFile   = destSel; // RL2
        end
        bais_pkg::OP_LIT_MINUS_WORK: begin
          result   = subSum[7:0]; // RL7
          newCarry = subSum[8]; // RL7
          wrWork   = 1'b1; // RL7
          updCarry = 1'b1; // RL7
          updHalf  = 1'b1; // RL7
          updZero  = 1'b1; // RL7
        end
        bais_pkg::OP_SLEEP:  doSleep = 1'b1; // RL10
        bais_pkg::OP_RETURN: doReturn = 1'b1; // RL11
        default:             result = bais_pkg::BYTE_ZERO;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      bais_pkg::STATE_RUN: begin
        if (take && doReturn) begin
          nxt_state = bais_pkg::STATE_RET2; // RL11
        end else if (take && doSleep) begin
          nxt_state = bais_pkg::STATE_SLEEP; // RL10
        end
      end
      bais_pkg::STATE_RET2:  nxt_state = bais_pkg::STATE_RUN; // RL11
      // only reset leaves sleep here; wake-up sits elsewhere
      bais_pkg::STATE_SLEEP: nxt_state = bais_pkg::STATE_SLEEP; // RL10
      default:               nxt_state = bais_pkg::STATE_RUN;
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= bais_pkg::STATE_RUN;
    end else if (clkEn) begin
      state_ff <= nxt_state;
    end
  end
  assign oscRun    = (state_ff != bais_pkg::STATE_SLEEP); // RL10
  assign sleepMode = (state_ff == bais_pkg::STATE_SLEEP);
  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pwrite && !rdErr_ff && clkEn;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && rdErr_ff;
  assign prdata   = rdata_ff;
  // read data is captured in the setup cycle, so it may be one beat stale
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= bais_pkg::RDATA_ZERO;
      rdErr_ff <= 1'b0;
    end else if (clkEn && apbSetup) begin
      rdErr_ff <= !isMapped(paddr);
      rdata_ff <= bais_pkg::RDATA_ZERO;
      case (paddr)
        bais_pkg::REG_CTRL:   rdata_ff[bais_pkg::CTRL_WDT_EN] <= wdtEn_ff;
        bais_pkg::REG_STATUS: begin
          rdata_ff[bais_pkg::ST_CARRY] <= carry_ff;
          rdata_ff[bais_pkg::ST_HALF]  <= half_carry_flag_ff;
          rdata_ff[bais_pkg::ST_ZERO]  <= zero_ff;
          rdata_ff[bais_pkg::ST_PD]    <= powerdown_status_bit_ff;
          rdata_ff[bais_pkg::ST_TO]    <= timeout_status_bit_ff;
          rdata_ff[bais_pkg::ST_SLEEP] <= sleepMode;
        end
        bais_pkg::REG_WORK:   rdata_ff[7:0] <= work_ff;
        bais_pkg::REG_PC:     rdata_ff[12:0] <= program_counter_ff;
        bais_pkg::REG_WDT:    rdata_ff[7:0] <= watchdog_counter_ff;
        bais_pkg::REG_FSEL:   rdata_ff[6:0] <= fsel_ff;
        bais_pkg::REG_FDATA:  rdata_ff[7:0] <= fileMem[fsel_ff];
        default:              rdata_ff <= bais_pkg::RDATA_ZERO;
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wdtEn_ff <= 1'b0;
      fsel_ff  <= bais_pkg::FSEL_RST;
    end else if (apbWrite) begin
      if (paddr == bais_pkg::REG_CTRL) begin
        wdtEn_ff <= pwdata[bais_pkg::CTRL_WDT_EN];
      end
      if (paddr == bais_pkg::REG_FSEL) begin
        fsel_ff <= pwdata[6:0];
      end
    end
  end
  // ---------------------------------------------------------------
  // file registers, an instruction write beats a bus write
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (take && wrFile) begin
      fileMem[fileAddr] <= result; // RL2
    end else if (apbWrite && (paddr == bais_pkg::REG_FDATA)) begin
      fileMem[fsel_ff] <= pwdata[7:0];
    end
  end
  // ---------------------------------------------------------------
  // work register and flags
  // ---------------------------------------------------------------
  assign busWork = apbWrite && (paddr == bais_pkg::REG_WORK);
  assign busStat = apbWrite && (paddr == bais_pkg::REG_STATUS);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      work_ff <= bais_pkg::BYTE_ZERO;
    end else if (take && wrWork) begin
      work_ff <= result; // RL2
    end else if (busWork) begin
      work_ff <= pwdata[7:0];
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      carry_ff           <= 1'b0;
      half_carry_flag_ff <= 1'b0;
      zero_ff            <= 1'b0;
    end else if (clkEn) begin
      if (take && updCarry) begin
        carry_ff <= newCarry; // RL4 RL5 RL7
      end else if (busStat) begin
        carry_ff <= pwdata[bais_pkg::ST_CARRY];
      end
      if (take && updHalf) begin
        half_carry_flag_ff <= subNib[4]; // RL7
      end else if (busStat) begin
        half_carry_flag_ff <= pwdata[bais_pkg::ST_HALF];
      end
      if (take && updZero) begin
        zero_ff <= (result == bais_pkg::BYTE_ZERO); // RL1 RL3 RL7
      end else if (busStat) begin
        zero_ff <= pwdata[bais_pkg::ST_ZERO];
      end
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      powerdown_status_bit_ff <= bais_pkg::PD_RST;
      timeout_status_bit_ff   <= bais_pkg::TO_RST;
    end else if (take && doSleep) begin
      powerdown_status_bit_ff <= 1'b0; // RL9
      timeout_status_bit_ff   <= 1'b1; // RL9
    end
  end
  // ---------------------------------------------------------------
  // watchdog, keeps counting through sleep as wake-up needs it
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      watchdog_counter_ff <= bais_pkg::WDT_CLR;
      presc_ff            <= bais_pkg::WDT_CLR;
    end else if (clkEn) begin
      if (take && doSleep) begin
        watchdog_counter_ff <= bais_pkg::WDT_CLR; // RL8
        presc_ff            <= bais_pkg::WDT_CLR; // RL8
      end else if (wdtEn_ff) begin
        if (presc_ff == bais_pkg::PRESC_MAX) begin
          presc_ff            <= bais_pkg::WDT_CLR;
          watchdog_counter_ff <= watchdog_counter_ff + bais_pkg::WDT_ONE;
        end else begin
          presc_ff <= presc_ff + bais_pkg::WDT_ONE;
        end
      end
    end
  end
  // ---------------------------------------------------------------
  // return stack, circular so overflow overwrites the oldest entry
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (pushTake) begin
      stackMem[stkPtr_ff] <= callAddr;
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stkPtr_ff          <= bais_pkg::PTR_RST;
      program_counter_ff <= bais_pkg::PC_RST;
    end else if (take && doReturn) begin
      program_counter_ff <= stackMem[popIdx]; // RL11
      stkPtr_ff          <= popIdx; // RL11
    end else if (pushTake) begin
      stkPtr_ff <= stkPtr_ff + bais_pkg::PTR_ONE;
    end
  end
  assign programCounter = program_counter_ff;
endmodule

`default_nettype wire

// ==== testbench/bais_core_monitor.sv ====
// assertions on the ports of the byte alu core
// assumes one clock domain and an active-low asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module bais_core_monitor (
  // clock and reset
  input wire logic                        core_clk,
  input wire logic                        rst_b,
  // instruction side
  input wire logic                        clkEn,
  input wire logic                        opValid,
  input wire bais_pkg::bais_op_t          opCode,
  input wire logic                        opReady,
  input wire logic [bais_pkg::PC_W-1:0]   programCounter,
  input wire logic                        oscRun,
  input wire logic                        sleepMode,
  // apb
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic [bais_pkg::APB_AW-1:0] paddr,
  input wire logic [bais_pkg::APB_DW-1:0] prdata,
  input wire logic                        pready,
  input wire logic                        pslverr
);
  logic retTaken;
  logic slpTaken;
  assign retTaken = opValid && opReady && clkEn && opCode == bais_pkg::OP_RETURN;
  assign slpTaken = opValid && opReady && clkEn && opCode == bais_pkg::OP_SLEEP;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  ret_stall_a: assert property (retTaken |=> !opReady ##1 opReady)
    else $error("return did not stall for exactly one cycle");
  pc_cause_a: assert property (!$stable(programCounter) |-> $past(retTaken))
    else $error("program counter moved without a return");
  ready_cause_a: assert property (!opReady |-> sleepMode || $past(retTaken))
    else $error("instruction port stalled without cause");
  sleep_halt_a: assert property (slpTaken |=> sleepMode && !oscRun && !opReady)
    else $error("sleep did not halt the core");
  sleep_hold_a: assert property (sleepMode |=> sleepMode)
    else $error("core left sleep without reset");
  osc_inverse_a: assert property (oscRun != sleepMode)
    else $error("oscillator state disagrees with sleep state");
  pready_high_a: assert property (pready)
    else $error("apb slave inserted a wait");
  err_map_a: assert property (psel && penable |->
    pslverr == (paddr > bais_pkg::REG_FDATA || paddr[1:0] != 2'b00))
    else $error("slave error does not match the address map");
  rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data changed outside a setup cycle");
endmodule
bind bais_core bais_core_monitor u_mon (.core_clk, .rst_b, .clkEn, .opValid, .opCode,
  .opReady, .programCounter, .oscRun, .sleepMode, .psel, .penable, .paddr, .prdata,
  .pready, .pslverr);
`default_nettype wire

// ==== testbench/bais_decode_model.sv ====
// model of the decode logic that offers instructions and stack pushes
// assumes tasks are called right after a rising edge of core_clk
`timescale 1ns/1ps
`default_nettype none
module bais_decode_model (
  // clock and handshake
  input  wire logic                    core_clk,
  input  wire logic                    opReady,
  // instruction offer
  output logic                         opValid,
  output bais_pkg::bais_op_t           opCode,
  output logic [bais_pkg::FADDR_W-1:0] fileAddr,
  output logic                         destSel,
  output logic [bais_pkg::DATA_W-1:0]  literalVal,
  // return stack push
  output logic                         callPush,
  output logic [bais_pkg::PC_W-1:0]    callAddr
);
  logic rdyS;
  initial begin
    opValid = 1'b0;
    opCode = bais_pkg::OP_NOP;
    fileAddr = 7'h00;
    destSel = 1'b0;
    literalVal = 8'h00;
    callPush = 1'b0;
    callAddr = 13'h0000;
  end
  // ready is combinational, so it is looked at away from the rising edge
  always @(negedge core_clk) rdyS <= opReady;
  task automatic issue(input bais_pkg::bais_op_t op, input logic [6:0] a,
                       input logic d, input logic [7:0] k);
    opValid <= 1'b1;
    opCode <= op;
    fileAddr <= a;
    destSel <= d;
    literalVal <= k;
    do @(posedge core_clk); while (rdyS !== 1'b1);
    // idle fields carry junk so a stale value is never trusted
    opValid <= 1'b0;
    fileAddr <= ~a;
    destSel <= ~d;
    literalVal <= ~k;
    // one idle edge so a following offer never reassigns in this step
    @(posedge core_clk);
  endtask
  task automatic push(input logic [12:0] a);
    callPush <= 1'b1;
    callAddr <= a;
    do @(posedge core_clk); while (rdyS !== 1'b1);
    callPush <= 1'b0;
    callAddr <= ~a;
    @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// self-checking bench for the byte alu core, apb master plus decode model
// assumes the monitor is bound to the core and a 100 MHz core clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clkEn = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic opValid, destSel, callPush, opReady, oscRun, sleepMode, pready, pslverr;
  bais_pkg::bais_op_t opCode, op;
  logic [6:0] fileAddr, fa;
  logic [7:0] literalVal, fv, w, k, res;
  logic [12:0] callAddr, programCounter;
  logic [31:0] prdata, r;
  logic [32:0] expQ[$];
  logic [32:0] ev;
  logic [2:0] fl, expFl;
  logic d;
  int fail_count = 0;
  int n_tests = 0;
  logic [31:0] seed = 32'h46c4c916;
  bais_core u_bais_core (.core_clk(core_clk), .rst_b(rst_b), .clkEn(clkEn),
    .opValid(opValid), .opCode(opCode), .fileAddr(fileAddr), .destSel(destSel),
    .literalVal(literalVal), .opReady(opReady), .callPush(callPush),
    .callAddr(callAddr), .programCounter(programCounter), .oscRun(oscRun),
    .sleepMode(sleepMode), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  bais_decode_model u_bais_decode_model (.core_clk(core_clk), .opReady(opReady),
    .opValid(opValid), .opCode(opCode), .fileAddr(fileAddr), .destSel(destSel),
    .literalVal(literalVal), .callPush(callPush), .callAddr(callAddr));
  always #5 core_clk = ~core_clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // ---------------------------------------------------------------
  // apb master, one idle edge after each transfer
  // ---------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dt);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dt;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~dt;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    apb(1'b1, a, dt);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expQ.push_back(e);
    apb(1'b0, a, rnd());
  endtask
  always @(posedge core_clk) begin
    if (psel && penable && pready && !pwrite && expQ.size() > 0) begin
      ev = expQ.pop_front();
      n_tests++;
      if ({pslverr, prdata} !== ev) begin
        $display("BAD %0t read %h got %b %h want %h", $time, paddr, pslverr, prdata, ev);
        fail_count++;
      end
    end
  end
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    test_done();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    rd(bais_pkg::REG_STATUS, 33'h18);
    rd(bais_pkg::REG_PC, 33'h0);
    rd(8'h1c, {1'b1, 32'h0});
    $display("test reset and map done");
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      fa = r[6:0];
      d = r[7];
      fl = r[10:8];
      fv = (i == 0) ? 8'hff : r[18:11];
      w = r[26:19];
      op = bais_pkg::bais_op_t'(3'(1 + i % 4));
      wr(bais_pkg::REG_FSEL, {25'h0, fa});
      wr(bais_pkg::REG_FDATA, {24'h0, fv});
      wr(bais_pkg::REG_WORK, {24'h0, w});
      wr(bais_pkg::REG_STATUS, {29'h0, fl});
      u_bais_decode_model.issue(op, fa, d, r[31:24]);
      case (op)
        bais_pkg::OP_INC_FILE: begin res = fv + 8'h01; expFl = {res == 8'h00, fl[1:0]}; end
        bais_pkg::OP_OR_WORK_FILE: begin res = w | fv; expFl = {res == 8'h00, fl[1:0]}; end
        bais_pkg::OP_ROT_LEFT: begin res = {fv[6:0], fl[0]}; expFl = {fl[2:1], fv[7]}; end
        default: begin res = {fl[0], fv[7:1]}; expFl = {fl[2:1], fv[0]}; end
      endcase
      rd(bais_pkg::REG_WORK, {25'h0, d ? w : res});
      rd(bais_pkg::REG_FDATA, {25'h0, d ? res : fv});
      rd(bais_pkg::REG_STATUS, {30'h3, expFl});
    end
    $display("test file ops done");
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      w = (i == 1) ? 8'h01 : r[7:0];
      k = (i == 0) ? w : ((i == 1) ? 8'h00 : r[15:8]);
      wr(bais_pkg::REG_WORK, {24'h0, w});
      wr(bais_pkg::REG_STATUS, {29'h0, r[18:16]});
      u_bais_decode_model.issue(bais_pkg::OP_LIT_MINUS_WORK, r[25:19], r[26], k);
      res = k - w;
      rd(bais_pkg::REG_WORK, {25'h0, res});
      rd(bais_pkg::REG_STATUS, {30'h3, res == 8'h00, k[3:0] >= w[3:0], k >= w});
    end
    $display("test literal subtract done");
    // with the enable low neither a bus write nor an offered op may land
    clkEn <= 1'b0;
    wr(bais_pkg::REG_WORK, {24'h0, ~res});
    u_bais_decode_model.issue(bais_pkg::OP_INC_FILE, 7'h00, 1'b0, 8'h00);
    clkEn <= 1'b1;
    rd(bais_pkg::REG_WORK, {25'h0, res});
    $display("test clock enable done");
    wr(bais_pkg::REG_STATUS, 32'h5);
    u_bais_decode_model.push(13'h1abc);
    u_bais_decode_model.push(13'h0123);
    u_bais_decode_model.issue(bais_pkg::OP_RETURN, 7'h00, 1'b0, 8'h00);
    u_bais_decode_model.issue(bais_pkg::OP_RETURN, 7'h00, 1'b0, 8'h00);
    rd(bais_pkg::REG_PC, 33'h1abc);
    rd(bais_pkg::REG_STATUS, 33'h1d);
    $display("test return done");
    // wdt runs long enough to leave nonzero counter and prescaler
    wr(bais_pkg::REG_CTRL, 32'h1);
    repeat (300) @(posedge core_clk);
    u_bais_decode_model.issue(bais_pkg::OP_SLEEP, 7'h00, 1'b0, 8'h00);
    rd(bais_pkg::REG_WDT, 33'h0);
    rd(bais_pkg::REG_STATUS, 33'h35);
    n_tests++;
    if (oscRun !== 1'b0 || opReady !== 1'b0) begin
      $display("BAD %0t core still running after sleep", $time);
      fail_count++;
    end
    repeat (240) @(posedge core_clk);
    rd(bais_pkg::REG_WDT, 33'h0);
    $display("test sleep done");
    rst_b <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    rd(bais_pkg::REG_STATUS, 33'h18);
    $display("test second reset done");
    test_done();
  end
endmodule
`default_nettype wire
